// >>> verilog/bsr_pkg.sv
// Constants shared by the boot status reporting block.
// Assumes a single 10 MHz system clock and byte-wide RAM and SFR ports.
package bsr_pkg;

   //////////////////////////////////////////////////////////////////////////
   // RAM side: address width and the boot variable locations
   localparam int             RAM_AW        = 13;
   localparam logic [12:0]    RES_PTR_ADDR  = 13'h11f3;
   localparam logic [12:0]    USER_BEG_ADDR = 13'h11f5;
   localparam logic [12:0]    NEXT_NVM_ADDR = 13'h11fd;
   localparam logic [12:0]    RESULT_ADDR   = 13'h11ff;
   localparam logic [12:0]    LSB_STEP      = 13'h0001;
   localparam logic [2:0]     WR_LAST_IDX   = 3'h4;

   //////////////////////////////////////////////////////////////////////////
   // Boot result byte layout
   localparam int             RES_PIN0_BIT  = 7;
   localparam int             RES_FACT_LSB  = 2;
   localparam int             RES_FACT_W    = 3;
   localparam int             RES_LATER_BIT = 1;
   localparam int             RES_FIRST_BIT = 0;
   localparam int             RES_RSV_LSB   = 5;
   localparam int             RES_RSV_W     = 2;
   localparam logic [7:0]     RES_OK_A      = 8'h00;
   localparam logic [7:0]     RES_OK_B      = 8'h80;

   //////////////////////////////////////////////////////////////////////////
   // SFR map and boot control bits
   localparam logic [7:0]     BOOT_CTRL_SFR  = 8'hdd;
   localparam logic [7:0]     PROG_LEVEL_SFR = 8'hde;
   localparam int             FORCE_FACT_BIT = 5;
   localparam int             RUN_POR_BIT    = 4;
   localparam int             FAIL_BIT       = 2;
   localparam int             DONE_BIT       = 1;
   localparam int             RUN_SYS_BIT    = 0;
   localparam logic [7:0]     FORCE_FACT_VAL = 8'h20;
   localparam logic [7:0]     CTRL_RESET     = 8'h00;

   //////////////////////////////////////////////////////////////////////////
   // Program levels of the part
   localparam logic [1:0]     LVL_FACTORY   = 2'h0;
   localparam logic [1:0]     LVL_USER      = 2'h1;
   localparam logic [1:0]     LVL_RUN       = 2'h2;

   // Boot sequence states
   typedef enum logic [3:0] {
      S_IDLE   = 4'h0,
      S_FACT   = 4'h1,
      S_RD_HI  = 4'h2,
      S_RD_LO  = 4'h3,
      S_RD_CAP = 4'h4,
      S_USER   = 4'h5,
      S_WR     = 4'h6,
      S_FIN    = 4'h7,
      S_WAIT   = 4'h8,
      S_RUN    = 4'h9
   } bsr_state_t;

endpackage

// >>> verilog/bsr_ctrl_reg.sv
// Boot control SFR: software bits plus hardware-set done and fail flags.
// Assumes writes are already decoded by the caller; por_i marks power up.
`timescale 1ns/10ps
module bsr_ctrl_reg
(
   input  wire logic       mclk_i,
   input  wire logic       reset_i,
   input  wire logic       por_i,
   input  wire logic       wr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       set_done_i,
   input  wire logic       set_fail_i,
   output logic      [7:0] ctrl_o
);

   typedef struct packed {
      logic [7:0] ctrl;
   } bsr_ctrl_st_t;

   bsr_ctrl_st_t st_r;
   bsr_ctrl_st_t st_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Next value; hardware sets win over a software write in the same cycle
   always_comb
   begin
      st_nxt = st_r;
      if (wr_i)
      begin
         st_nxt.ctrl = wdata_i;
      end
      if (set_done_i)
      begin
         st_nxt.ctrl[bsr_pkg::DONE_BIT] = 1'b1;
      end
      if (set_fail_i)
      begin
         st_nxt.ctrl[bsr_pkg::FAIL_BIT] = 1'b1;
      end
      // Force bit survives a plain reset, only power up clears it
      if (por_i)
      begin
         st_nxt.ctrl = bsr_pkg::CTRL_RESET;
      end
      else if (reset_i)
      begin
         st_nxt.ctrl = bsr_pkg::CTRL_RESET;
         st_nxt.ctrl[bsr_pkg::FORCE_FACT_BIT] = st_r.ctrl[bsr_pkg::FORCE_FACT_BIT];
      end
   end

   // State register
   always_ff @(posedge mclk_i)
   begin
      st_r <= st_nxt;
   end

   assign ctrl_o = st_r.ctrl;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_force_write: assert property (@(posedge mclk_i) disable iff (reset_i || por_i)
      (wr_i && wdata_i == bsr_pkg::FORCE_FACT_VAL) |=> ctrl_o[bsr_pkg::FORCE_FACT_BIT])
      else $error("force factory bit not set after write");
   a_done_sets: assert property (@(posedge mclk_i) disable iff (reset_i || por_i)
      set_done_i |=> ctrl_o[bsr_pkg::DONE_BIT])
      else $error("done flag not set at boot end");
   a_por_clears: assert property (@(posedge mclk_i)
      por_i |=> ctrl_o == bsr_pkg::CTRL_RESET)
      else $error("control register not cleared at power up");

endmodule // bsr_ctrl_reg

// >>> verilog/bsr_top.sv
// Boot status reporting: runs the end of the boot load and leaves the
// pointer words and result byte at the top of RAM.
// Assumes a loader that signals factory and user block results, a RAM
// with one cycle read latency, and an SFR port on the same clock.
`timescale 1ns/10ps
module bsr_top
(
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   input  wire logic        por_i,
   input  wire logic        gpio0_i,
   input  wire logic [1:0]  prog_level_i,
   input  wire logic        user_cont_i,
   input  wire logic        dbg_attach_i,
   input  wire logic        fact_done_i,
   input  wire logic [2:0]  fact_err_i,
   input  wire logic [15:0] res_ptr_i,
   input  wire logic        user_blk_i,
   input  wire logic        user_blk_err_i,
   input  wire logic        user_done_i,
   input  wire logic        nvm_rd_i,
   input  wire logic [15:0] nvm_rd_addr_i,
   input  wire logic        ld_wr_i,
   input  wire logic [15:0] ld_addr_i,
   input  wire logic [7:0]  ram_rdata_i,
   input  wire logic        sfr_wr_i,
   input  wire logic        sfr_rd_i,
   input  wire logic [7:0]  sfr_addr_i,
   input  wire logic [7:0]  sfr_wdata_i,
   output logic             fact_req_o,
   output logic             user_req_o,
   output logic      [15:0] user_start_o,
   output logic             ram_we_o,
   output logic             ram_re_o,
   output logic      [12:0] ram_addr_o,
   output logic      [7:0]  ram_wdata_o,
   output logic      [7:0]  sfr_rdata_o,
   output logic      [7:0]  boot_ctrl_o,
   output logic             halted_o,
   output logic             code_run_o,
   output logic             res_hit_o
);

   typedef struct packed {
      bsr_pkg::bsr_state_t state;
      logic                pin0;
      logic [2:0]          ferr;
      logic                first_err;
      logic                later_err;
      logic                blk_seen;
      logic [15:0]         res_ptr;
      logic [7:0]          ubeg_hi;
      logic [15:0]         ubeg;
      logic [15:0]         next_rd;
      logic [2:0]          idx;
      logic                halt;
      logic                fact_req;
      logic                user_req;
      logic                ram_we;
      logic                ram_re;
      logic [12:0]         ram_addr;
      logic [7:0]          ram_wdata;
      logic [7:0]          sfr_rdata;
      logic                done_p;
      logic                fail_p;
      logic                code_run;
      logic                res_hit;
      logic                halted;
   } bsr_main_st_t;

   bsr_main_st_t st_r;
   bsr_main_st_t st_nxt;
   logic [7:0]   ctrl_w;
   logic [7:0]   res_byte;
   logic         ctrl_wr;
   logic         force_fact;
   logic         run_now;

   ////////////////////////////////////////////////////////////////////////////
   // Boot control register, kept apart so power-up and reset differ
   assign ctrl_wr    = sfr_wr_i && (sfr_addr_i == bsr_pkg::BOOT_CTRL_SFR);
   assign force_fact = ctrl_w[bsr_pkg::FORCE_FACT_BIT];

   bsr_ctrl_reg u_ctrl
   (
      .mclk_i     (mclk_i),
      .reset_i    (reset_i),
      .por_i      (por_i),
      .wr_i       (ctrl_wr),
      .wdata_i    (sfr_wdata_i),
      .set_done_i (st_r.done_p),
      .set_fail_i (st_r.fail_p),
      .ctrl_o     (ctrl_w)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Result byte built from the captured errors; reserved bits stay zero
   always_comb
   begin
      res_byte = 8'h00;
      res_byte[bsr_pkg::RES_PIN0_BIT] = st_r.pin0;
      res_byte[bsr_pkg::RES_FACT_LSB +: bsr_pkg::RES_FACT_W] = st_r.ferr;
      res_byte[bsr_pkg::RES_LATER_BIT] = st_r.later_err;
      res_byte[bsr_pkg::RES_FIRST_BIT] = st_r.first_err;
   end

   // Run straight away only for a run part or an auto-run user part
   assign run_now = !st_r.halt && ((prog_level_i == bsr_pkg::LVL_RUN) ||
                    (prog_level_i == bsr_pkg::LVL_USER && user_cont_i && !force_fact));

   ////////////////////////////////////////////////////////////////////////////
   // Boot sequence
   always_comb
   begin
      st_nxt          = st_r;
      st_nxt.ram_we   = 1'b0;
      st_nxt.ram_re   = 1'b0;
      st_nxt.done_p   = 1'b0;
      st_nxt.fail_p   = 1'b0;
      st_nxt.fact_req = 1'b0;

      // Next unread address tracks every byte the copy process reads
      if (nvm_rd_i)
         st_nxt.next_rd = nvm_rd_addr_i + 16'h0001;

      // Loader writes into the reserved area during the user load are flagged, never blocked
      if (ld_wr_i && (ld_addr_i >= st_r.res_ptr) && (st_r.state == bsr_pkg::S_USER))
         st_nxt.res_hit = 1'b1;

      case (st_r.state)
         bsr_pkg::S_IDLE:
         begin
            // Pin sampled before anything else, ahead of the oscillator
            st_nxt.pin0      = gpio0_i;
            st_nxt.ferr      = 3'h0;
            st_nxt.first_err = 1'b0;
            st_nxt.later_err = 1'b0;
            st_nxt.blk_seen  = 1'b0;
            st_nxt.idx       = 3'h0;
            st_nxt.fact_req  = 1'b1;
            st_nxt.state     = bsr_pkg::S_FACT;
         end
         bsr_pkg::S_FACT:
         begin
            st_nxt.fact_req = !fact_done_i;
            if (fact_done_i)
            begin
               st_nxt.ferr    = fact_err_i;
               st_nxt.res_ptr = res_ptr_i;
               st_nxt.ram_re  = 1'b1;
               st_nxt.ram_addr = bsr_pkg::USER_BEG_ADDR;
               st_nxt.state   = bsr_pkg::S_RD_HI;
            end
         end
         bsr_pkg::S_RD_HI:
         begin
            // Low byte requested while the high byte is on its way
            st_nxt.ram_re   = 1'b1;
            st_nxt.ram_addr = bsr_pkg::USER_BEG_ADDR + bsr_pkg::LSB_STEP;
            st_nxt.state    = bsr_pkg::S_RD_LO;
         end
         bsr_pkg::S_RD_LO:
         begin
            st_nxt.ubeg_hi = ram_rdata_i;
            st_nxt.state   = bsr_pkg::S_RD_CAP;
         end
         bsr_pkg::S_RD_CAP:
         begin
            st_nxt.ubeg = {st_r.ubeg_hi, ram_rdata_i};
            if (prog_level_i == bsr_pkg::LVL_FACTORY || force_fact)
               st_nxt.state = bsr_pkg::S_WR;
            else
            begin
               st_nxt.user_req = 1'b1;
               st_nxt.state    = bsr_pkg::S_USER;
            end
         end
         bsr_pkg::S_USER:
         begin
            if (user_blk_i)
            begin
               st_nxt.blk_seen = 1'b1;
               if (user_blk_err_i && !st_r.blk_seen)
                  st_nxt.first_err = 1'b1;
               if (user_blk_err_i && st_r.blk_seen)
                  st_nxt.later_err = 1'b1;
            end
            if (user_done_i)
            begin
               st_nxt.user_req = 1'b0;
               st_nxt.state    = bsr_pkg::S_WR;
            end
         end
         bsr_pkg::S_WR:
         begin
            // Words go out MSB first at the lower address
            st_nxt.ram_we = 1'b1;
            case (st_r.idx)
               3'h0:
               begin
                  st_nxt.ram_addr  = bsr_pkg::RES_PTR_ADDR;
                  st_nxt.ram_wdata = st_r.res_ptr[15:8];
               end
               3'h1:
               begin
                  st_nxt.ram_addr  = bsr_pkg::RES_PTR_ADDR + bsr_pkg::LSB_STEP;
                  st_nxt.ram_wdata = st_r.res_ptr[7:0];
               end
               3'h2:
               begin
                  st_nxt.ram_addr  = bsr_pkg::NEXT_NVM_ADDR;
                  st_nxt.ram_wdata = st_r.next_rd[15:8];
               end
               3'h3:
               begin
                  st_nxt.ram_addr  = bsr_pkg::NEXT_NVM_ADDR + bsr_pkg::LSB_STEP;
                  st_nxt.ram_wdata = st_r.next_rd[7:0];
               end
               default:
               begin
                  st_nxt.ram_addr  = bsr_pkg::RESULT_ADDR;
                  st_nxt.ram_wdata = res_byte;
               end
            endcase
            st_nxt.idx = st_r.idx + 3'h1;
            if (st_r.idx == bsr_pkg::WR_LAST_IDX)
               st_nxt.state = bsr_pkg::S_FIN;
         end
         bsr_pkg::S_FIN:
         begin
            st_nxt.done_p = 1'b1;
            st_nxt.fail_p = (res_byte != bsr_pkg::RES_OK_A);
            st_nxt.state  = run_now ? bsr_pkg::S_RUN : bsr_pkg::S_WAIT;
            st_nxt.code_run = run_now;
         end
         bsr_pkg::S_WAIT:
         begin
            // Waiting loop left for S_RUN whenever a run bit is set, whether written before or during the wait
            if (ctrl_w[bsr_pkg::RUN_SYS_BIT] || ctrl_w[bsr_pkg::RUN_POR_BIT])
            begin
               st_nxt.code_run = 1'b1;
               st_nxt.halt     = 1'b0;
               st_nxt.state    = bsr_pkg::S_RUN;
            end
         end
         bsr_pkg::S_RUN:
            st_nxt.code_run = 1'b1;
         default:
            st_nxt.state = bsr_pkg::S_IDLE;
      endcase

      // Protection register and control register reads
      if (sfr_rd_i)
      begin
         case (sfr_addr_i)
            bsr_pkg::BOOT_CTRL_SFR:  st_nxt.sfr_rdata = ctrl_w;
            bsr_pkg::PROG_LEVEL_SFR: st_nxt.sfr_rdata = {6'h00, prog_level_i};
            default:                 st_nxt.sfr_rdata = 8'h00;
         endcase
      end

      // Debugger attach restarts the boot and keeps the part halted
      if (dbg_attach_i)
      begin
         st_nxt.state    = bsr_pkg::S_IDLE;
         st_nxt.halt     = 1'b1;
         st_nxt.code_run = 1'b0;
         st_nxt.user_req = 1'b0;
      end

      // Every reset reruns the whole boot, factory reload included
      if (reset_i)
      begin
         st_nxt          = '0;
         st_nxt.state    = bsr_pkg::S_IDLE;
      end
      st_nxt.halted = (st_nxt.state == bsr_pkg::S_WAIT);      // Registered wait flag
   end

   // State register
   always_ff @(posedge mclk_i)
   begin
      st_r <= st_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from the state register or the control register
   assign fact_req_o   = st_r.fact_req;
   assign user_req_o   = st_r.user_req;
   assign user_start_o = st_r.ubeg;
   assign ram_we_o     = st_r.ram_we;
   assign ram_re_o     = st_r.ram_re;
   assign ram_addr_o   = st_r.ram_addr;
   assign ram_wdata_o  = st_r.ram_wdata;
   assign sfr_rdata_o  = st_r.sfr_rdata;
   assign boot_ctrl_o  = ctrl_w;
   assign halted_o     = st_r.halted;
   assign code_run_o   = st_r.code_run;
   assign res_hit_o    = st_r.res_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_ptr_be_order: assert property (@(posedge mclk_i) disable iff (reset_i)
      (ram_we_o && ram_addr_o == bsr_pkg::RES_PTR_ADDR)
      |-> ram_wdata_o == st_r.res_ptr[15:8]
      ##1 (ram_we_o && ram_addr_o == bsr_pkg::RES_PTR_ADDR + bsr_pkg::LSB_STEP
           && ram_wdata_o == st_r.res_ptr[7:0]))
      else $error("reserved pointer not written big-endian");
   a_user_start: assert property (@(posedge mclk_i) disable iff (reset_i)
      $rose(user_req_o) |-> $past(ram_re_o, 3)
          && user_start_o == {$past(ram_rdata_i, 2), $past(ram_rdata_i)})
      else $error("user load started before start word read");
   a_next_unread: assert property (@(posedge mclk_i) disable iff (reset_i)
      nvm_rd_i |=> st_r.next_rd == $past(nvm_rd_addr_i) + 16'h0001)
      else $error("next unread address not one past last read");
   a_next_written: assert property (@(posedge mclk_i) disable iff (reset_i)
      (ram_we_o && ram_addr_o == bsr_pkg::NEXT_NVM_ADDR)
      |-> ram_wdata_o == st_r.next_rd[15:8])
      else $error("next unread address high byte wrong");
   a_result_byte: assert property (@(posedge mclk_i) disable iff (reset_i)
      (ram_we_o && ram_addr_o == bsr_pkg::RESULT_ADDR)
      |-> ram_wdata_o[bsr_pkg::RES_RSV_LSB +: bsr_pkg::RES_RSV_W] == 2'h0
          && ram_wdata_o[bsr_pkg::RES_PIN0_BIT] == st_r.pin0
          && ram_wdata_o[bsr_pkg::RES_FACT_LSB +: bsr_pkg::RES_FACT_W] == st_r.ferr)
      else $error("result byte layout wrong");
   a_fail_flag: assert property (@(posedge mclk_i) disable iff (reset_i || por_i)
      (st_r.state == bsr_pkg::S_FIN && res_byte != bsr_pkg::RES_OK_A)
      |-> ##2 boot_ctrl_o[bsr_pkg::FAIL_BIT])
      else $error("fail flag missing after nonzero result");
   a_force_no_user: assert property (@(posedge mclk_i) disable iff (reset_i)
      (st_r.state == bsr_pkg::S_RD_CAP && force_fact) |=> !user_req_o)
      else $error("user load started while forced to factory");
   a_fact_reload: assert property (@(posedge mclk_i)
      $fell(reset_i) |-> ##[1:2] fact_req_o)
      else $error("factory load not requested after reset");
   a_dbg_halt: assert property (@(posedge mclk_i) disable iff (reset_i)
      dbg_attach_i |=> !code_run_o && st_r.halt)
      else $error("part not halted after debugger attach");
   a_prog_level: assert property (@(posedge mclk_i) disable iff (reset_i)
      (sfr_rd_i && sfr_addr_i == bsr_pkg::PROG_LEVEL_SFR)
      |=> sfr_rdata_o == {6'h00, $past(prog_level_i)})
      else $error("program level read back wrong");
   a_first_err: assert property (@(posedge mclk_i) disable iff (reset_i)
      (st_r.state == bsr_pkg::S_USER && user_blk_i && user_blk_err_i && !st_r.blk_seen
       && !dbg_attach_i)
      |=> st_r.first_err)
      else $error("first block error not captured");

endmodule // bsr_top

// >>> tb/bsr_top_tb.sv
// Self-checking bench for the boot status reporting block.
// Assumes bsr_pkg and bsr_top are compiled first; bench acts as loader, RAM and SFR host.
`timescale 1ns/10ps
module bsr_top_tb;
   typedef struct packed
   {
      logic pin; logic [1:0] lvl; logic [2:0] fe; logic e1; logic e2; logic cont; logic hit;
   } bsr_row_t;
   logic        mclk_i, reset_i, por_i, gpio0_i, user_cont_i, dbg_attach_i, fact_done_i;
   logic        user_blk_i, user_blk_err_i, user_done_i, nvm_rd_i, ld_wr_i, sfr_wr_i, sfr_rd_i;
   logic [1:0]  prog_level_i;
   logic [2:0]  fact_err_i;
   logic [15:0] res_ptr_i, nvm_rd_addr_i, ld_addr_i, user_start_o;
   logic [7:0]  ram_rdata_i, sfr_addr_i, sfr_wdata_i, ram_wdata_o, sfr_rdata_o, boot_ctrl_o, d;
   logic        fact_req_o, user_req_o, ram_we_o, ram_re_o, halted_o, code_run_o, res_hit_o;
   logic [12:0] ram_addr_o;
   logic [7:0]  ram [0:8191];
   logic        force_on, dbg_on;
   int          miscompares, checks_done;
   bsr_row_t    rows [6];
   //////////////////////////////////////////////////////////////////////////
   bsr_top i_bsr_top
   (
      .mclk_i(mclk_i), .reset_i(reset_i), .por_i(por_i), .gpio0_i(gpio0_i),
      .prog_level_i(prog_level_i), .user_cont_i(user_cont_i), .dbg_attach_i(dbg_attach_i),
      .fact_done_i(fact_done_i), .fact_err_i(fact_err_i), .res_ptr_i(res_ptr_i),
      .user_blk_i(user_blk_i), .user_blk_err_i(user_blk_err_i), .user_done_i(user_done_i),
      .nvm_rd_i(nvm_rd_i), .nvm_rd_addr_i(nvm_rd_addr_i), .ld_wr_i(ld_wr_i),
      .ld_addr_i(ld_addr_i), .ram_rdata_i(ram_rdata_i), .sfr_wr_i(sfr_wr_i),
      .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
      .fact_req_o(fact_req_o), .user_req_o(user_req_o), .user_start_o(user_start_o),
      .ram_we_o(ram_we_o), .ram_re_o(ram_re_o), .ram_addr_o(ram_addr_o),
      .ram_wdata_o(ram_wdata_o), .sfr_rdata_o(sfr_rdata_o), .boot_ctrl_o(boot_ctrl_o),
      .halted_o(halted_o), .code_run_o(code_run_o), .res_hit_o(res_hit_o)
   );
   // 10 MHz clock
   always #50 mclk_i = ~mclk_i;
   // RAM stand-in; idle read data toggles so stale bytes never look valid
   always @(posedge mclk_i)
   begin
      if (ram_we_o)
         ram[ram_addr_o] <= ram_wdata_o;
      ram_rdata_i <= ram_re_o ? ram[ram_addr_o] : ~ram_rdata_i;
   end
   //////////////////////////////////////////////////////////////////////////
   task chk8(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task chk16(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task chk1(input logic g, input logic e);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task end_sim;
      $display("checks_done %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Reset held 16 cycles; p also clears the power-up state
   task rst(input logic p);
      @(posedge mclk_i);
      reset_i <= 1'b1;
      por_i <= p;
      repeat (16) @(posedge mclk_i);
      reset_i <= 1'b0;
      por_i <= 1'b0;
   endtask
   task sfr_wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk_i);
      sfr_wr_i <= 1'b1;
      sfr_addr_i <= a;
      sfr_wdata_i <= v;
      @(posedge mclk_i);
      sfr_wr_i <= 1'b0;
   endtask
   task sfr_rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk_i);
      sfr_rd_i <= 1'b1;
      sfr_addr_i <= a;
      @(posedge mclk_i);
      sfr_rd_i <= 1'b0;
      @(posedge mclk_i);
      #1 v = sfr_rdata_o;
   endtask
   //////////////////////////////////////////////////////////////////////////
   // One full boot: restart, factory load, two user blocks unless factory-only, then result check
   task automatic boot(input bsr_row_t r);
      logic        fl, run;
      logic [7:0]  res;
      logic [15:0] st;
      fl = (r.lvl == bsr_pkg::LVL_FACTORY) || force_on;
      run = !dbg_on && !fl && (r.lvl == bsr_pkg::LVL_RUN || r.cont);
      res = {r.pin, 2'h0, r.fe, fl ? 2'h0 : {r.e2, r.e1}};
      st = 16'h1234;
      // Poison the status area so a missed write cannot pass on stale data
      for (int a = 'h11f3; a < 'h1200; a++)
         ram[a] = 8'hxx;
      ram['h11f5] = 8'h12;
      ram['h11f6] = 8'h34;
      @(posedge mclk_i);
      prog_level_i <= r.lvl;
      user_cont_i <= r.cont;
      gpio0_i <= r.pin;
      if (dbg_on)
      begin
         @(posedge mclk_i);
         dbg_attach_i <= 1'b1;
         @(posedge mclk_i);
         dbg_attach_i <= 1'b0;
      end
      else
         rst(1'b0);
      repeat (2) @(posedge mclk_i);
      gpio0_i <= ~r.pin;
      #1;
      repeat (10) if (fact_req_o !== 1'b1) #100;
      chk1(fact_req_o, 1'b1);
      @(posedge mclk_i);
      fact_done_i <= 1'b1;
      fact_err_i <= r.fe;
      res_ptr_i <= 16'h1100;
      @(posedge mclk_i);
      fact_done_i <= 1'b0;
      if (!fl)
      begin
         #1;
         repeat (20) if (user_req_o !== 1'b1) #100;
         chk16(user_start_o, st);
         @(posedge mclk_i);
         {user_blk_i, user_blk_err_i, nvm_rd_i, nvm_rd_addr_i, ld_wr_i} <= {1'b1, r.e1, 1'b1, st, 1'b1};
         ld_addr_i <= r.hit ? 16'h1100 : 16'h10ff;
         @(posedge mclk_i);
         {user_blk_err_i, nvm_rd_addr_i, ld_wr_i} <= {r.e2, st + 16'h0001, 1'b0};
         @(posedge mclk_i);
         {user_blk_i, nvm_rd_i, user_done_i} <= 3'b001;
         @(posedge mclk_i);
         user_done_i <= 1'b0;
      end
      #1;
      repeat (40) if (boot_ctrl_o[bsr_pkg::DONE_BIT] !== 1'b1) #100;
      #300;
      chk8(ram['h11ff], res);
      chk16({ram['h11f3], ram['h11f4]}, 16'h1100);
      if (!fl)
         chk16({ram['h11fd], ram['h11fe]}, st + 16'h0002);
      chk1(boot_ctrl_o[bsr_pkg::DONE_BIT], 1'b1);
      chk1(boot_ctrl_o[bsr_pkg::FAIL_BIT], res != 8'h00);
      chk1(res_hit_o, !fl && r.hit);
      chk1(code_run_o, run);
      chk1(halted_o, !run);
   endtask
   //////////////////////////////////////////////////////////////////////////
   // Watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      #2000000;
      miscompares++;
      end_sim();
   end
   initial
   begin
      {mclk_i, reset_i, por_i, gpio0_i, user_cont_i, dbg_attach_i, fact_done_i} = 7'h30;
      {user_blk_i, user_blk_err_i, user_done_i, nvm_rd_i, ld_wr_i, sfr_wr_i, sfr_rd_i} = 7'h00;
      {prog_level_i, fact_err_i, res_ptr_i, nvm_rd_addr_i, ld_addr_i} = 53'h0;
      {ram_rdata_i, sfr_addr_i, sfr_wdata_i} = 24'h0;
      {force_on, dbg_on, miscompares, checks_done} = 0;
      rows = '{'{1'b0, bsr_pkg::LVL_USER, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0},
               '{1'b1, bsr_pkg::LVL_USER, 3'h0, 1'b0, 1'b0, 1'b1, 1'b1},
               '{1'b0, bsr_pkg::LVL_RUN, 3'h5, 1'b1, 1'b0, 1'b0, 1'b0},
               '{1'b1, bsr_pkg::LVL_RUN, 3'h7, 1'b0, 1'b1, 1'b0, 1'b1},
               '{1'b0, bsr_pkg::LVL_FACTORY, 3'h2, 1'b1, 1'b1, 1'b1, 1'b0},
               '{1'b1, bsr_pkg::LVL_FACTORY, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0}};
      rst(1'b1);
      #1 chk8(boot_ctrl_o, bsr_pkg::CTRL_RESET);
      foreach (rows[i])
         boot(rows[i]);
      sfr_rd(bsr_pkg::BOOT_CTRL_SFR, d);
      chk8(d, 8'h06);
      @(posedge mclk_i);
      prog_level_i <= bsr_pkg::LVL_RUN;
      sfr_rd(bsr_pkg::PROG_LEVEL_SFR, d);
      chk8(d, 8'h02);
      sfr_rd(8'h00, d);
      chk8(d, 8'h00);
      // Force bit must survive plain resets, and only power-up clears it
      sfr_wr(bsr_pkg::BOOT_CTRL_SFR, bsr_pkg::FORCE_FACT_VAL);
      force_on = 1'b1;
      repeat (2) boot(rows[1]);
      sfr_rd(bsr_pkg::BOOT_CTRL_SFR, d);
      chk8(d, 8'h26);
      force_on = 1'b0;
      rst(1'b1);
      #1 chk8(boot_ctrl_o, bsr_pkg::CTRL_RESET);
      // Debugger attach on a run part ends halted until a run bit is set
      dbg_on = 1'b1;
      boot(rows[2]);
      sfr_wr(bsr_pkg::BOOT_CTRL_SFR, 8'h01);
      #101 chk1(code_run_o, 1'b1);
      chk1(halted_o, 1'b0);
      // Second attach, released through the other run bit
      sfr_wr(bsr_pkg::BOOT_CTRL_SFR, 8'h00);
      boot(rows[2]);
      sfr_wr(bsr_pkg::BOOT_CTRL_SFR, 8'h10);
      #101 chk1(code_run_o, 1'b1);
      chk1(halted_o, 1'b0);
      end_sim();
   end
endmodule // bsr_top_tb
